/* File: acsr_map.svh */
`ifndef ACSR_MAP_SVH
`define ACSR_MAP_SVH

// system clock and converter master clock
`define ACSR_CLK_HZ 20000000
`define ACSR_CONVERTER_MASTER_CLOCK_HZ 2500000
`define ACSR_CONVERTER_MASTER_CLOCK_DIV (`ACSR_CLK_HZ / `ACSR_CONVERTER_MASTER_CLOCK_HZ)

// conversion length in divided clock periods
`define ACSR_CONV_DCLKS 16
// serial start waits for this many divided clock falling edges
`define ACSR_SER_START_EDGES 2
// pin start waits for this many master clock falling edges
`define ACSR_PIN_START_EDGES 2

// instruction byte fields
`define ACSR_INS_START_BIT 7
`define ACSR_INS_READ_BIT 6
`define ACSR_INS_WIDE_BIT 5
`define ACSR_INS_ADDR_HI 4
`define ACSR_INS_ADDR_LO 0

// register addresses
`define ACSR_ADDR_RES_LO 5'h00
`define ACSR_ADDR_RES_HI 5'h01
`define ACSR_ADDR_CTRL 5'h03
`define ACSR_ADDR_GAINMUX 5'h04
`define ACSR_ADDR_GAINMUX2 5'h05

// data byte fields
`define ACSR_REQ_BIT 7
`define ACSR_RBM_HI 3
`define ACSR_RBM_LO 2
`define ACSR_CFD_HI 1
`define ACSR_CFD_LO 0

// reset values
`define ACSR_RBM_RST 2'h0
`define ACSR_CFD_RST 2'h0

`endif

/* File: acsr_pkg.sv */
package acsr_pkg;
  typedef logic [15:0] acsr_word_t;
  typedef logic [1:0] acsr_sel_t;
  typedef enum logic {
    ACSR_CONV_IDLE = 1'b0,
    ACSR_CONV_RUN = 1'b1
  } acsr_conv_e;
  typedef enum logic [1:0] {
    ACSR_PH_INSTR = 2'b00,
    ACSR_PH_WDATA = 2'b01,
    ACSR_PH_READ = 2'b11
  } acsr_phase_e;
  // read word selection
  localparam acsr_sel_t ACSR_SEL_MSB16 = 2'h0;
  localparam acsr_sel_t ACSR_SEL_LSB16 = 2'h1;
  localparam acsr_sel_t ACSR_SEL_MSB8 = 2'h2;
endpackage

/* File: acsr_sync.sv */
`timescale 1ns/100ps
module acsr_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_level
);
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic [3:0] s3_reg;
  wire [3:0] agree = ~(s2_reg ^ s3_reg);
  wire [3:0] level_next = (agree & s3_reg) | (~agree & pin_level);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // bit 1 carries chip select, which idles high
      s1_reg <= 4'h2;
      s2_reg <= 4'h2;
      s3_reg <= 4'h2;
      pin_level <= 4'h2;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_level <= level_next;
    end
  end
endmodule

/* File: acsr_core.sv */
`timescale 1ns/100ps
`include "acsr_map.svh"
// Contract
// - start byte or request bit write starts
// - serial start on second divided falling edge
// - busy rises one divided period after start
// - busy falls when conversion completes
// - request during conversion is queued
// - queue one deep, newer request overwrites
// - queued conversion starts at completion, no gap
// - pin rise starts on second master edge
// - pin start aborts running conversion
// - pin start ignores chip select
// - control register mode bits, default mode 0
// - mode 0 read address 1 msb first
// - read returns last completed result
// - mode 1 auto read msb first
// - mode 2 auto read lsb first
// - mode 3 auto read msb byte only
// - only serial starts arm auto read
// - first bit active edge, rest active edge too
module acsr_core (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic convert,
  input wire acsr_pkg::acsr_word_t adc_data,
  output logic dout,
  output logic dout_oe_n,
  output logic busy,
  output logic [1:0] readback_mode,
  output logic [1:0] clock_divider
);
  import acsr_pkg::*;

  function automatic acsr_word_t sel_word(input acsr_word_t w, input acsr_sel_t s);
    sel_word = (s == ACSR_SEL_LSB16) ? {w[7:0], w[15:8]} : w;
  endfunction

  function automatic acsr_sel_t mode_sel(input logic [1:0] m);
    mode_sel = (m == 2'h2) ? ACSR_SEL_LSB16 : ((m == 2'h3) ? ACSR_SEL_MSB8 : ACSR_SEL_MSB16);
  endfunction

  // reset release
  logic rst1_reg;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst1_reg <= 1'b1;
      rst_n <= rst1_reg;
    end
  end

  // pin synchronisation
  logic [3:0] lvl;
  logic [3:0] lvl_d_reg;
  acsr_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in({convert, din, cs_n, sclk}),
    .pin_level(lvl)
  );
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lvl_d_reg <= 4'h2;
    else lvl_d_reg <= lvl;
  end
  wire sclk_l = lvl[0];
  wire cs_l_n = lvl[1];
  wire din_l = lvl[2];
  wire sclk_rise = sclk_l & ~lvl_d_reg[0];
  wire sclk_fall = ~sclk_l & lvl_d_reg[0];
  wire conv_rise = lvl[3] & ~lvl_d_reg[3];

  // master clock and divided clock ticks
  logic [2:0] converter_master_clock_cnt_reg;
  logic [2:0] divided_conversion_clock_cnt_reg;
  localparam logic [2:0] CONVERTER_MASTER_CLOCK_LAST = 3'(`ACSR_CONVERTER_MASTER_CLOCK_DIV - 1);
  wire converter_master_clock_tick = (converter_master_clock_cnt_reg == CONVERTER_MASTER_CLOCK_LAST);
  wire [2:0] divided_conversion_clock_last = (3'h1 << clock_divider) - 3'h1;
  wire divided_conversion_clock_tick = converter_master_clock_tick & (divided_conversion_clock_cnt_reg >= divided_conversion_clock_last);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) converter_master_clock_cnt_reg <= 3'h0;
    else converter_master_clock_cnt_reg <= converter_master_clock_tick ? 3'h0 : converter_master_clock_cnt_reg + 3'h1;
  end

  // serial front end
  acsr_phase_e phase_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] rx_reg;
  logic [4:0] addr_reg;
  logic [4:0] rd_len_reg;
  acsr_sel_t rd_sel_reg;
  acsr_word_t tx_reg;
  logic ser_req;
  logic ser_auto;
  wire [7:0] rx_byte = {rx_reg[6:0], din_l};
  wire byte_done = sclk_rise & ~cs_l_n & (bit_cnt_reg == 3'h7);
  wire ins_start = rx_byte[`ACSR_INS_START_BIT];
  wire ins_read = rx_byte[`ACSR_INS_READ_BIT];
  wire ins_wide = rx_byte[`ACSR_INS_WIDE_BIT];
  wire [4:0] ins_addr = rx_byte[`ACSR_INS_ADDR_HI:`ACSR_INS_ADDR_LO];
  wire wr_req_addr = (addr_reg == `ACSR_ADDR_GAINMUX) | (addr_reg == `ACSR_ADDR_GAINMUX2);
  wire in_instr = (phase_reg == ACSR_PH_INSTR);
  wire in_wdata = (phase_reg == ACSR_PH_WDATA);
  wire in_read = (phase_reg == ACSR_PH_READ);
  assign ser_req = byte_done & ((in_instr & ins_start) | (in_wdata & wr_req_addr & rx_byte[`ACSR_REQ_BIT]));
  assign ser_auto = ser_req & (readback_mode != 2'h0);
  wire ctrl_wr = byte_done & in_wdata & (addr_reg == `ACSR_ADDR_CTRL);
  wire exp_read = byte_done & in_instr & ~ins_start & ins_read;
  wire acsr_sel_t exp_sel = (~ins_wide) ? ACSR_SEL_MSB8 :
    ((ins_addr == `ACSR_ADDR_RES_LO) ? ACSR_SEL_LSB16 : ACSR_SEL_MSB16);
  wire acsr_sel_t auto_sel = mode_sel(readback_mode);
  wire rd_first = in_read & sclk_rise & ~cs_l_n & (rd_len_reg == 5'h00);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readback_mode <= `ACSR_RBM_RST;
      clock_divider <= `ACSR_CFD_RST;
    end else if (ctrl_wr) begin
      readback_mode <= rx_byte[`ACSR_RBM_HI:`ACSR_RBM_LO];
      clock_divider <= rx_byte[`ACSR_CFD_HI:`ACSR_CFD_LO];
    end
  end

  // conversion control
  acsr_conv_e conv_reg;
  logic [4:0] conv_cnt_reg;
  logic queued_reg;
  logic [1:0] arm_cnt_reg;
  logic armed_reg;
  logic [1:0] pin_cnt_reg;
  logic pin_wait_reg;
  acsr_word_t result_reg;
  wire running = (conv_reg == ACSR_CONV_RUN);
  wire conv_end = running & divided_conversion_clock_tick & (conv_cnt_reg == 5'(`ACSR_CONV_DCLKS - 1));
  wire ser_go = armed_reg & divided_conversion_clock_tick & (arm_cnt_reg == 2'(`ACSR_SER_START_EDGES - 1));
  wire pin_go = pin_wait_reg & converter_master_clock_tick & (pin_cnt_reg == 2'(`ACSR_PIN_START_EDGES - 1));
  wire ser_start = ser_go & ~running;
  wire ser_queue = (ser_req & running) | (ser_go & running);
  wire queue_go = conv_end & queued_reg & ~pin_go;
  wire conv_start = pin_go | ser_start | queue_go;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_reg <= 1'b0;
      arm_cnt_reg <= 2'h0;
    end else if (ser_req & ~running) begin
      armed_reg <= 1'b1;
      arm_cnt_reg <= 2'h0;
    end else if (ser_go) begin
      armed_reg <= 1'b0;
    end else if (armed_reg & divided_conversion_clock_tick) begin
      arm_cnt_reg <= arm_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_wait_reg <= 1'b0;
      pin_cnt_reg <= 2'h0;
    end else if (conv_rise) begin
      pin_wait_reg <= 1'b1;
      pin_cnt_reg <= 2'h0;
    end else if (pin_go) begin
      pin_wait_reg <= 1'b0;
    end else if (pin_wait_reg & converter_master_clock_tick) begin
      pin_cnt_reg <= pin_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) queued_reg <= 1'b0;
    else if (ser_queue) queued_reg <= 1'b1;
    else if (queue_go) queued_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_reg <= ACSR_CONV_IDLE;
      conv_cnt_reg <= 5'h00;
      divided_conversion_clock_cnt_reg <= 3'h0;
      busy <= 1'b0;
    end else if (conv_start) begin
      conv_reg <= ACSR_CONV_RUN;
      conv_cnt_reg <= 5'h00;
      divided_conversion_clock_cnt_reg <= 3'h0;
      busy <= 1'b0;
    end else begin
      if (converter_master_clock_tick) divided_conversion_clock_cnt_reg <= (divided_conversion_clock_cnt_reg >= divided_conversion_clock_last) ? 3'h0 : divided_conversion_clock_cnt_reg + 3'h1;
      if (conv_end) begin
        conv_reg <= ACSR_CONV_IDLE;
        busy <= 1'b0;
      end else if (running & divided_conversion_clock_tick) begin
        conv_cnt_reg <= conv_cnt_reg + 5'h01;
        busy <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) result_reg <= 16'h0000;
    else if (conv_end) result_reg <= adc_data;
  end

  // serial sequencing and readback shifter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= ACSR_PH_INSTR;
      bit_cnt_reg <= 3'h0;
      rx_reg <= 8'h00;
      addr_reg <= 5'h00;
      rd_len_reg <= 5'h00;
      rd_sel_reg <= ACSR_SEL_MSB16;
    end else if (cs_l_n) begin
      phase_reg <= ACSR_PH_INSTR;
      bit_cnt_reg <= 3'h0;
      rd_len_reg <= 5'h00;
    end else if (sclk_rise) begin
      rx_reg <= rx_byte;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (in_read) begin
        rd_len_reg <= rd_len_reg + 5'h01;
        if (rd_len_reg + 5'h01 == ((rd_sel_reg == ACSR_SEL_MSB8) ? 5'h08 : 5'h10)) begin
          phase_reg <= ACSR_PH_INSTR;
          bit_cnt_reg <= 3'h0;
          rd_len_reg <= 5'h00;
        end
      end else if (byte_done) begin
        if (ser_auto) begin
          phase_reg <= ACSR_PH_READ;
          rd_sel_reg <= auto_sel;
        end else if (exp_read) begin
          phase_reg <= ACSR_PH_READ;
          rd_sel_reg <= exp_sel;
        end else if (in_instr & ~ins_start) begin
          phase_reg <= ACSR_PH_WDATA;
          addr_reg <= ins_addr;
        end else begin
          phase_reg <= ACSR_PH_INSTR;
        end
      end
    end
  end

  wire acsr_word_t rd_word = sel_word(result_reg, rd_sel_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg <= 16'h0000;
      dout <= 1'b0;
      dout_oe_n <= 1'b1;
    end else if (cs_l_n) begin
      dout_oe_n <= 1'b1;
    end else if (rd_first) begin
      dout <= rd_word[15];
      dout_oe_n <= 1'b0;
    end else if (in_read & sclk_fall & (rd_len_reg == 5'h01)) begin
      tx_reg <= {rd_word[14:0], 1'b0};
    end else if (in_read & sclk_rise) begin
      dout <= tx_reg[15];
      tx_reg <= {tx_reg[14:0], 1'b0};
    end else if (~in_read & sclk_fall) begin
      dout_oe_n <= 1'b1;
    end
  end
endmodule

/* File: acsr_core_properties.sv */
`timescale 1ns/100ps
module acsr_core_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic convert,
  input wire acsr_pkg::acsr_word_t adc_data,
  input wire logic dout,
  input wire logic dout_oe_n,
  input wire logic busy,
  input wire logic [1:0] readback_mode,
  input wire logic [1:0] clock_divider
);
  import acsr_pkg::*;
  logic [13:0] high_reg;
  logic pin_reg;
  logic [13:0] lim;
  // busy high time of a full conversion in clk cycles
  assign lim = 14'h0078 << clock_divider;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      high_reg <= 14'h0000;
      pin_reg <= 1'b0;
    end else begin
      high_reg <= busy ? high_reg + 14'h0001 : 14'h0000;
      pin_reg <= busy & (pin_reg | convert);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence low_gap;
    !busy [*8];
  endsequence
  sequence low_gap2;
    low_gap ##1 low_gap;
  endsequence
  busy_len_a: assert property ($fell(busy) && !pin_reg |-> high_reg == lim) else $error("busy length");
  busy_max_a: assert property (busy |-> high_reg < lim) else $error("busy too long");
  gap_fast_a: assert property ($fell(busy) && clock_divider == 2'h0 |-> low_gap) else $error("gap short");
  gap_half_a: assert property ($fell(busy) && clock_divider == 2'h1 |-> low_gap2) else $error("gap short");
  pin_start_a: assert property ($rose(convert) && clock_divider == 2'h0 |-> ##[12:60] $rose(busy))
    else $error("pin start late");
  port_idle_a: assert property (cs_n [*8] |-> dout_oe_n) else $error("dout driven idle");
  cfg_hold_a: assert property (cs_n [*8] |=> $stable(readback_mode) && $stable(clock_divider))
    else $error("config changed");
  oe_frame_a: assert property (!dout_oe_n |-> !$past(cs_n, 8)) else $error("dout early");
endmodule

bind acsr_core acsr_core_properties chk (.clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .din(din),
  .convert(convert), .adc_data(adc_data), .dout(dout), .dout_oe_n(dout_oe_n), .busy(busy),
  .readback_mode(readback_mode), .clock_divider(clock_divider));

/* File: acsr_host_model.sv */
`timescale 1ns/100ps
module acsr_host_model (
  input wire logic clk,
  input wire logic dout,
  output logic sclk,
  output logic cs_n,
  output logic din,
  output logic convert
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    convert = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse();
    convert <= 1'b1;
    tick(16);
    convert <= 1'b0;
  endtask
  // instruction then nb bits, msb first; din toggles while released
  task automatic frame(input logic [7:0] ins, input logic [7:0] wd, input int nb, output logic [15:0] rd);
    logic rf;
    rf = ins[7] | ins[6];
    rd = 16'h0000;
    cs_n <= 1'b0;
    for (int i = 0; i < nb + 8; i++) begin
      // sample at the falling edge, while the line is still driven
      if (rf && i > 8) rd = {rd[14:0], dout};
      din <= (rf && i > 7) ? ~din : (i < 8 ? ins[7 - i] : wd[15 - i]);
      sclk <= 1'b0;
      tick(6);
      sclk <= 1'b1;
      tick(6);
    end
    if (rf && nb > 0) rd = {rd[14:0], dout};
    sclk <= 1'b0;
    tick(6);
    cs_n <= 1'b1;
    din <= ~din;
    tick(8);
  endtask
endmodule

/* File: adc_conversion_start_readback_tb.sv */
`timescale 1ns/100ps
module adc_conversion_start_readback_tb;
  import acsr_pkg::*;
  logic clk, resetn, sclk, cs_n, din, convert, dout, dout_oe_n, busy;
  acsr_word_t adc_data;
  logic [1:0] readback_mode;
  logic [1:0] clock_divider;
  int err_total = 0;
  int checks_done = 0;
  acsr_core dut (.clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .din(din), .convert(convert),
    .adc_data(adc_data), .dout(dout), .dout_oe_n(dout_oe_n), .busy(busy), .readback_mode(readback_mode),
    .clock_divider(clock_divider));
  // pull-up on the data line while the block releases it
  wire dout_line = dout_oe_n ? 1'b1 : dout;
  acsr_host_model h (.clk(clk), .dout(dout_line), .sclk(sclk), .cs_n(cs_n), .din(din), .convert(convert));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input acsr_word_t got, input acsr_word_t exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_busy(input logic lvl, input int lim, output int n);
    n = 0;
    while (busy !== lvl) begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        chk({15'h0000, busy}, {15'h0000, lvl});
        stop_test();
      end
    end
  endtask
  initial begin
    int n;
    acsr_word_t rd;
    logic flag;
    resetn = 1'b0;
    adc_data = 16'h1234;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    h.tick(8);
    chk({12'h000, readback_mode, clock_divider}, 16'h0000);
    h.frame(8'h80, 8'h00, 0, rd);
    wait_busy(1'b1, 20, n);
    wait_busy(1'b0, 200, n);
    h.frame(8'h61, 8'h00, 16, rd);
    chk(rd, 16'h1234);
    h.frame(8'h60, 8'h00, 16, rd);
    chk(rd, 16'h3412);
    h.frame(8'h41, 8'h00, 8, rd);
    chk(rd, 16'h0012);
    h.frame(8'h03, 8'h01, 8, rd);
    chk({14'h0000, clock_divider}, 16'h0001);
    adc_data <= 16'hbeef;
    h.frame(8'h04, 8'h80, 8, rd);
    wait_busy(1'b1, 60, n);
    h.frame(8'h61, 8'h00, 16, rd);
    chk(rd, 16'h1234);
    wait_busy(1'b0, 300, n);
    h.frame(8'h61, 8'h00, 16, rd);
    chk(rd, 16'hbeef);
    h.frame(8'h03, 8'h02, 8, rd);
    h.frame(8'h80, 8'h00, 0, rd);
    wait_busy(1'b1, 120, n);
    h.frame(8'h80, 8'h00, 0, rd);
    h.frame(8'h04, 8'h80, 8, rd);
    wait_busy(1'b0, 600, n);
    wait_busy(1'b1, 40, n);
    chk(16'(n), 16'h0020);
    wait_busy(1'b0, 600, n);
    chk(16'(n), 16'h01e0);
    flag = 1'b0;
    repeat (300) begin
      @(posedge clk);
      flag = flag | busy;
    end
    chk({15'h0000, flag}, 16'h0000);
    h.frame(8'h03, 8'h00, 8, rd);
    adc_data <= 16'h5aa5;
    h.pulse();
    wait_busy(1'b1, 40, n);
    chk({15'h0000, dout_oe_n}, 16'h0001);
    h.tick(40);
    h.pulse();
    wait_busy(1'b0, 20, n);
    wait_busy(1'b1, 40, n);
    wait_busy(1'b0, 200, n);
    chk(16'(n), 16'h0078);
    for (int m = 1; m < 4; m++) begin
      h.frame(8'h03, {4'h0, 2'(m), 2'h0}, 8, rd);
      chk({14'h0000, readback_mode}, 16'(m));
      h.frame(8'h80, 8'h00, (m == 3) ? 8 : 16, rd);
      chk(rd, (m == 1) ? 16'h5aa5 : (m == 2) ? 16'ha55a : 16'h005a);
      wait_busy(1'b0, 300, n);
    end
    stop_test();
  end
endmodule
